// ==== rtl/cws_pkg.sv ====
// Package with register map, field positions and shared types of the waveform shutdown controller.
package cws_pkg;
    // Register byte addresses on the Avalon-MM bus (word aligned).
    localparam logic [3:0] ADDR_CONTROL_0   = 4'h0;
    localparam logic [3:0] ADDR_SHUTDOWN    = 4'h4;
    localparam logic [3:0] ADDR_DEADBAND_R  = 4'h8;
    localparam logic [3:0] ADDR_DEADBAND_F  = 4'hc;
    localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h0;
    localparam logic [3:0] ADDR_IRQ_MASK    = 4'h4;
    localparam logic [0:0] PAGE_CORE        = 1'h0;
    localparam logic [0:0] PAGE_IRQ         = 1'h1;

    // Control register 0 field positions.
    localparam int C0_MODULE_EN  = 7;
    localparam int C0_OE_B       = 6;
    localparam int C0_OE_A       = 5;
    localparam int C0_POL_B      = 4;
    localparam int C0_POL_A      = 3;
    localparam int C0_CLK_SEL    = 0;
    localparam logic [7:0] C0_WMASK = 8'hf9;

    // Shutdown control field positions.
    localparam int SD_ACTIVE     = 7;
    localparam int SD_AUTO_RST   = 6;
    localparam int SD_LVL_B      = 5;
    localparam int SD_LVL_A      = 4;
    localparam int SD_SRC_HI     = 1;
    localparam logic [7:0] SD_WMASK = 8'hf3;

    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam int         DB_W        = 6;
    localparam logic [5:0] DB_ZERO     = 6'h00;
    localparam logic [5:0] DB_ONE      = 6'h01;

    // Interrupt event bits.
    localparam int EV_SHUTDOWN = 0;
    localparam int EV_RESTART  = 1;
    localparam int EV_W        = 2;

    typedef enum logic [1:0] {
        CWS_RUN,
        CWS_SHUTDOWN,
        CWS_WAIT_EDGE
    } cws_state_e;

    typedef enum logic [1:0] {
        CWS_PH_LOW,
        CWS_PH_RISE_DB,
        CWS_PH_HIGH,
        CWS_PH_FALL_DB
    } cws_phase_e;

    // Pin group: output level and output enable (low while driving).
    typedef struct packed {
        logic a_out;
        logic a_oe_n;
        logic b_out;
        logic b_oe_n;
    } cws_pins_s;
endpackage

// ==== rtl/cws_ctrl.sv ====
// Complementary waveform generator with shutdown override, restart control and register slave.
//
// Contract
// RL1: Software makes pins inputs, disables, sets dead bands, shutdown, source, clock/polarity/enables, enables, then drives pins.
// RL2: Software programs both override levels before enabling because the unit starts in shutdown.
// RL3: During configuration software sets shutdown_active and clears auto_restart_enable to hold the overrides.
// RL4: Software starts waveforms by setting auto_restart_enable or by clearing shutdown_active.
// RL5: In shutdown each pin is driven to its own override level, A from field A and B from field B.
// RL6: Override levels are applied without the polarity inversion.
// RL7: auto_restart_enable chooses automatic or software recovery; when clear only a software write ends shutdown.
// RL8: A software clear of shutdown_active is ignored while any selected shutdown input is high.
// RL9: With auto restart, shutdown_active clears by itself once all selected shutdown inputs are low.
// RL10: After shutdown_active clears the overrides stay until the next rising input edge, then waveforms resume.
// RL11: Setting shutdown_active from software forces shutdown at once.
// RL12: A clear output enable releases its pin; a set one applies override or waveform.
// RL13: While module_enable is clear, enables and drive levels have no effect on the pins.
// RL14: Dead-band timing runs off system clock or fast oscillator per clock_source_select.
// RL15: Control 0 holds enable at bit 7, B/A enables at 6/5, B/A polarity at 4/3 and clock select at bit 0.
`timescale 1ns/1ps
module cws_ctrl
    import cws_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        wave_in,
    input  wire logic [1:0]  shutdown_in,
    input  wire logic        fast_osc_tick,
    output cws_pins_s        pins,
    output logic             irq
);
    // Registers.
    logic [7:0]       ctrl0_ff;
    logic [7:0]       sd_ff;
    logic [5:0]       db_rise_ff;
    logic [5:0]       db_fall_ff;
    logic [EV_W-1:0]  irq_stat_ff;
    logic [EV_W-1:0]  irq_mask_ff;
    logic             ack_ff;
    logic [31:0]      rdata_ff;
    logic             wave_d_ff;
    cws_state_e       state_ff;
    cws_phase_e       phase_ff;
    logic [5:0]       db_cnt_ff;
    cws_pins_s        pins_ff;
    logic             irq_ff;
    logic             waitreq_ff;

    // Combinational decode and next pin values.
    logic             req;
    logic             wr_hit;
    logic             fault;
    logic             rise_edge;
    logic             fall_edge;
    logic             db_tick;
    logic             sw_set;
    logic             sw_clr;
    logic             hw_clr;
    logic [EV_W-1:0]  ev;
    logic             wave_a;
    logic             wave_b;
    logic             nxt_a_out;
    logic             nxt_a_oe_n;
    logic             nxt_b_out;
    logic             nxt_b_oe_n;

    // Byte lane 0 merge honouring a write mask; other lanes hold nothing.
    // Upper lanes carry nothing because no register is wider than one byte.
    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
                                              input logic [3:0] be, input logic [7:0] wmask);
        merge_byte = be[0] ? ((old & ~wmask) | (wd[7:0] & wmask)) : old;
    endfunction

    // Address compare with the page bit in address bit 4.
    // Every address bit is compared, so no register shows up at a second address.
    function automatic logic hit(input logic [4:0] a, input logic [0:0] pg, input logic [3:0] off);
        hit = (a[4] == pg[0]) && (a[3:0] == off);
    endfunction

    // One-cycle answer: waitrequest is high by default and drops for a single cycle per request.
    // A request held through its answer cycle is masked by ack_ff and never lands twice.
    assign req    = (avs_read || avs_write) && !ack_ff;
    assign wr_hit = avs_write && !ack_ff;

    // Combined shutdown level from the selected sources; a source counts only if selected.
    // Sources are levels: while a selected one stays high no write can clear the active bit.
    assign fault     = |(shutdown_in & sd_ff[SD_SRC_HI:0]);
    assign rise_edge = wave_in && !wave_d_ff;
    assign fall_edge = !wave_in && wave_d_ff;
    // Dead-band counting advances per system clock or per fast-oscillator tick. [RL14]
    assign db_tick   = ctrl0_ff[C0_CLK_SEL] ? fast_osc_tick : 1'b1;

    // Software set and clear of the active bit; a write with lane 0 disabled touches neither.
    assign sw_set = wr_hit && hit(avs_address, PAGE_CORE, ADDR_SHUTDOWN) && avs_byteenable[0]
                    && avs_writedata[SD_ACTIVE];
    assign sw_clr = wr_hit && hit(avs_address, PAGE_CORE, ADDR_SHUTDOWN) && avs_byteenable[0]
                    && !avs_writedata[SD_ACTIVE];
    // Hardware clear needs auto restart, otherwise only software may end shutdown. [RL7] [RL9]
    assign hw_clr = sd_ff[SD_AUTO_RST] && !fault;

    // Bus handshake and read data. A request is committed at the edge where it is first seen;
    // waitrequest drops after that edge, which costs nothing since the master holds until then.
    // Read data are captured at that same edge and stand while waitrequest is low.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ack_ff     <= 1'b0;
            waitreq_ff <= 1'b1;
            rdata_ff   <= 32'h0000_0000;
        end else begin
            ack_ff     <= req;
            waitreq_ff <= !req; // Registered so the port comes straight from a flip-flop.
            if (req && avs_read) begin
                if (hit(avs_address, PAGE_CORE, ADDR_CONTROL_0)) begin
                    rdata_ff <= {24'h00_0000, ctrl0_ff};
                end else if (hit(avs_address, PAGE_CORE, ADDR_SHUTDOWN)) begin
                    rdata_ff <= {24'h00_0000, sd_ff};
                end else if (hit(avs_address, PAGE_CORE, ADDR_DEADBAND_R)) begin
                    rdata_ff <= {26'h000_0000, db_rise_ff};
                end else if (hit(avs_address, PAGE_CORE, ADDR_DEADBAND_F)) begin
                    rdata_ff <= {26'h000_0000, db_fall_ff};
                end else if (hit(avs_address, PAGE_IRQ, ADDR_IRQ_STATUS)) begin
                    rdata_ff <= {30'h0000_0000, irq_stat_ff};
                end else if (hit(avs_address, PAGE_IRQ, ADDR_IRQ_MASK)) begin
                    rdata_ff <= {30'h0000_0000, irq_mask_ff};
                end else begin
                    rdata_ff <= 32'h0000_0000; // Unmapped reads answer zero.
                end
            end
        end
    end

    // Control 0 and dead-band registers; reserved bits 2..1 stay zero.
    // The write mask drops reserved bits, so they always read back zero.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl0_ff   <= RESET_BYTE;
            db_rise_ff <= DB_ZERO;
            db_fall_ff <= DB_ZERO;
        end else if (wr_hit) begin
            if (hit(avs_address, PAGE_CORE, ADDR_CONTROL_0)) begin
                ctrl0_ff <= merge_byte(ctrl0_ff, avs_writedata, avs_byteenable, C0_WMASK); // [RL15]
            end
            if (hit(avs_address, PAGE_CORE, ADDR_DEADBAND_R) && avs_byteenable[0]) begin
                db_rise_ff <= avs_writedata[DB_W-1:0];
            end
            if (hit(avs_address, PAGE_CORE, ADDR_DEADBAND_F) && avs_byteenable[0]) begin
                db_fall_ff <= avs_writedata[DB_W-1:0];
            end
        end
    end

    // Shutdown register; the active bit is also set by a fault level, which wins over any clear.
    // Auto and software clears share one path, so both are held off by a fault level.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sd_ff <= RESET_BYTE;
        end else begin
            if (wr_hit && hit(avs_address, PAGE_CORE, ADDR_SHUTDOWN)) begin
                sd_ff <= merge_byte(sd_ff, avs_writedata, avs_byteenable, SD_WMASK);
            end
            if (fault || sw_set) begin
                sd_ff[SD_ACTIVE] <= 1'b1; // [RL11]
            end else if (sw_clr || hw_clr) begin
                sd_ff[SD_ACTIVE] <= 1'b0; // Clear only with every selected input low. [RL8]
            end else begin
                sd_ff[SD_ACTIVE] <= sd_ff[SD_ACTIVE];
            end
        end
    end

    // Input delay for edge detection. It resets low, the idle level of the source;
    // a source already high at release counts as one rising edge.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wave_d_ff <= 1'b0;
        end else begin
            wave_d_ff <= wave_in;
        end
    end

    // Run state: shutdown holds overrides, then waits for a rising input edge before resuming.
    // Shutdown is not left while any selected source is high, whichever clear was used.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= CWS_SHUTDOWN;
        end else begin
            if (sd_ff[SD_ACTIVE] || fault) begin
                state_ff <= CWS_SHUTDOWN;
            end else begin
                unique case (state_ff)
                    CWS_SHUTDOWN:  state_ff <= CWS_WAIT_EDGE;
                    CWS_WAIT_EDGE: state_ff <= rise_edge ? CWS_RUN : CWS_WAIT_EDGE; // [RL10]
                    CWS_RUN:       state_ff <= CWS_RUN;
                    default:       state_ff <= CWS_SHUTDOWN; // Unused code falls back to the safe state.
                endcase
            end
        end
    end

    // Dead-band sequencer: each input edge turns one side off at once and the other on after the count.
    // A zero count skips the wait; a pulse shorter than the count never turns the far side on.
    // Counting runs in shutdown too, so a restart edge always starts from a clean phase.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            phase_ff  <= CWS_PH_LOW;
            db_cnt_ff <= DB_ZERO;
        end else if (rise_edge) begin
            phase_ff  <= (db_rise_ff == DB_ZERO) ? CWS_PH_HIGH : CWS_PH_RISE_DB;
            db_cnt_ff <= DB_ZERO;
        end else if (fall_edge) begin
            phase_ff  <= (db_fall_ff == DB_ZERO) ? CWS_PH_LOW : CWS_PH_FALL_DB;
            db_cnt_ff <= DB_ZERO;
        end else if (db_tick) begin
            unique case (phase_ff)
                CWS_PH_RISE_DB: begin
                    db_cnt_ff <= db_cnt_ff + DB_ONE;
                    if (db_cnt_ff + DB_ONE >= db_rise_ff) phase_ff <= CWS_PH_HIGH;
                end
                CWS_PH_FALL_DB: begin
                    db_cnt_ff <= db_cnt_ff + DB_ONE;
                    if (db_cnt_ff + DB_ONE >= db_fall_ff) phase_ff <= CWS_PH_LOW;
                end
                CWS_PH_LOW, CWS_PH_HIGH: db_cnt_ff <= DB_ZERO;
            endcase
        end
    end

    // Raw pair before polarity: A follows the high phase and B the low phase.
    assign wave_a = (phase_ff == CWS_PH_HIGH);
    assign wave_b = (phase_ff == CWS_PH_LOW);

    // Pin levels: overrides bypass polarity, disabled module or output releases the pin.
    // Overrides are one bit per pin; a pin that must float is released through its enable.
    always_comb begin
        if (state_ff == CWS_RUN && !sd_ff[SD_ACTIVE] && !fault) begin
            nxt_a_out = wave_a ^ ctrl0_ff[C0_POL_A];
            nxt_b_out = wave_b ^ ctrl0_ff[C0_POL_B];
        end else begin
            nxt_a_out = sd_ff[SD_LVL_A]; // [RL5] [RL6]
            nxt_b_out = sd_ff[SD_LVL_B]; // [RL5] [RL6]
        end
        nxt_a_oe_n = !(ctrl0_ff[C0_MODULE_EN] && ctrl0_ff[C0_OE_A]); // [RL12] [RL13]
        nxt_b_oe_n = !(ctrl0_ff[C0_MODULE_EN] && ctrl0_ff[C0_OE_B]); // [RL12] [RL13]
        if (!ctrl0_ff[C0_MODULE_EN]) begin
            nxt_a_out = 1'b0;
            nxt_b_out = 1'b0;
        end
    end

    // Pin register: each pin signal leaves the block from a flip-flop, one cycle after its cause.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pins_ff <= '{a_out: 1'b0, a_oe_n: 1'b1, b_out: 1'b0, b_oe_n: 1'b1};
        end else begin
            pins_ff <= '{a_out: nxt_a_out, a_oe_n: nxt_a_oe_n, b_out: nxt_b_out, b_oe_n: nxt_b_oe_n};
        end
    end

    // Events: entry into shutdown and resumption of waveforms.
    // Entry counts only from run or wait, so a shutdown that is merely held never re-fires it.
    assign ev[EV_SHUTDOWN] = (state_ff != CWS_SHUTDOWN) && (sd_ff[SD_ACTIVE] || fault);
    assign ev[EV_RESTART]  = (state_ff == CWS_WAIT_EDGE) && rise_edge && !sd_ff[SD_ACTIVE] && !fault;

    // Sticky status with write-one-to-clear; a new event wins over a clear in the same cycle,
    // so an event that lands on the clearing write is never lost.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq_stat_ff <= 2'h0;
        end else if (wr_hit && hit(avs_address, PAGE_IRQ, ADDR_IRQ_STATUS) && avs_byteenable[0]) begin
            irq_stat_ff <= (irq_stat_ff & ~avs_writedata[EV_W-1:0]) | ev;
        end else begin
            irq_stat_ff <= irq_stat_ff | ev;
        end
    end

    // Interrupt mask with the same layout as the status register.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask_ff <= 2'h0;
        end else if (wr_hit && hit(avs_address, PAGE_IRQ, ADDR_IRQ_MASK) && avs_byteenable[0]) begin
            irq_mask_ff <= avs_writedata[EV_W-1:0];
        end
    end

    // Level interrupt, registered, so it lags the status by one cycle;
    // software sees it drop one cycle after the clearing write.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = waitreq_ff;
    assign pins            = pins_ff;
    assign irq             = irq_ff;
endmodule // cws_ctrl

// ==== verification/cws_ctrl_sva.sv ====
// Port-level assertions for the waveform shutdown controller.
`timescale 1ns/1ps
module cws_ctrl_sva
    import cws_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        wave_in,
    input wire logic [1:0]  shutdown_in,
    input wire cws_pins_s   pins
);
    logic       wr_c0;
    logic       wr_sd;
    logic [7:0] c0_ff;
    logic [7:0] sd_ff;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // A write lands where the request is first seen, so the shadows capture it there.
    assign wr_c0 = avs_write && avs_waitrequest && avs_byteenable[0] && avs_address == {PAGE_CORE, ADDR_CONTROL_0};
    assign wr_sd = avs_write && avs_waitrequest && avs_byteenable[0] && avs_address == {PAGE_CORE, ADDR_SHUTDOWN};

    // Shadow copies of the written control and shutdown bytes.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            c0_ff <= 8'h00;
            sd_ff <= 8'h00;
        end else begin
            c0_ff <= wr_c0 ? avs_writedata[7:0] : c0_ff;
            sd_ff <= wr_sd ? avs_writedata[7:0] : sd_ff;
        end
    end

    property p_answer; $rose(avs_read || avs_write) |=> !avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered after one cycle");
    property p_pulse; !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_pulse: assert property (p_pulse) else $error("waitrequest low longer than one cycle");
    property p_rd_zero; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000
        && (avs_address[4:3] != 2'h3 || avs_readdata[7:0] == 8'h00);
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("unused read bits not zero");
    property p_off; (!c0_ff[C0_MODULE_EN])[*3] |-> pins.a_oe_n && pins.b_oe_n && !pins.a_out && !pins.b_out;
    endproperty
    a_off: assert property (p_off) else $error("disabled module touches pins");
    property p_oe; (c0_ff[C0_MODULE_EN] && $stable(c0_ff))[*3]
        |-> pins.a_oe_n == !c0_ff[C0_OE_A] && pins.b_oe_n == !c0_ff[C0_OE_B];
    endproperty
    a_oe: assert property (p_oe) else $error("pin drive does not follow output enable");
    property p_force; wr_sd && avs_writedata[SD_ACTIVE] && &c0_ff[7:5]
        |-> ##4 pins.a_out == sd_ff[SD_LVL_A] && pins.b_out == sd_ff[SD_LVL_B];
    endproperty
    a_force: assert property (p_force) else $error("software set did not force overrides");
    property p_hold; wr_sd && !avs_writedata[SD_ACTIVE] && |(avs_writedata[1:0] & shutdown_in) && &c0_ff[7:5]
        |-> ##4 (pins.a_out == sd_ff[SD_LVL_A] && pins.b_out == sd_ff[SD_LVL_B])[*4];
    endproperty
    a_hold: assert property (p_hold) else $error("clear accepted during fault");
    property p_wait_edge; wr_sd && !avs_writedata[SD_ACTIVE] && !avs_writedata[SD_AUTO_RST] && &c0_ff[7:5]
        ##1 (!wave_in)[*6] |-> pins.a_out == sd_ff[SD_LVL_A] && pins.b_out == sd_ff[SD_LVL_B];
    endproperty
    a_wait_edge: assert property (p_wait_edge) else $error("overrides left before rising edge");
endmodule // cws_ctrl_sva

// ==== verification/cws_gate_model.sv ====
// Gate driver inputs seen on the two drive pins.
`timescale 1ns/1ps
module cws_gate_model
    import cws_pkg::*;
(
    input  wire cws_pins_s pins,
    output logic           gate_a,
    output logic           gate_b
);
    // A released pin falls to the driver's pull-down rather than keeping its last level.
    assign gate_a = pins.a_oe_n ? 1'b0 : pins.a_out;
    assign gate_b = pins.b_oe_n ? 1'b0 : pins.b_out;
endmodule // cws_gate_model

// ==== verification/cws_ctrl_tb_top.sv ====
// Self-checking bench for the waveform shutdown controller.
`timescale 1ns/1ps
module cws_ctrl_tb_top;
    import cws_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        wave_in = 1'b0;
    logic [1:0]  shutdown_in = 2'h0;
    logic        fast_osc_tick = 1'b0;
    logic        irq;
    logic        gate_a;
    logic        gate_b;
    cws_pins_s   pins;
    logic [31:0] rd;
    int          errors = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #10 ref_clk = ~ref_clk;

    // Oscillator tick on every fourth cycle; the cycle ceiling cuts a hang short.
    always @(posedge ref_clk) begin
        fast_osc_tick <= (cycles % 4 == 0);
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            report_and_stop();
        end
    end

    cws_ctrl u_dut (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wave_in(wave_in),
        .shutdown_in(shutdown_in), .fast_osc_tick(fast_osc_tick), .pins(pins), .irq(irq));
    cws_gate_model u_gate (.pins(pins), .gate_a(gate_a), .gate_b(gate_b));

    task automatic report_and_stop();
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic gates(input string what, input logic [1:0] exp);
        check(what, 32'(exp), 32'({gate_a, gate_b}));
    endtask

    // One bus cycle; waitrequest and read data are taken at a rising edge, then the request drops.
    task automatic bus(input logic wr, input logic [4:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        avs_address <= addr;
        avs_writedata <= {24'h000000, data};
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic drive(input logic w, input logic [1:0] f);
        @(posedge ref_clk);
        wave_in <= w;
        shutdown_in <= f;
    endtask

    task automatic t_regs();
        bus(1'b0, 5'h00, 8'h00);
        check("control0 reset", 32'h0, rd);
        bus(1'b0, 5'h04, 8'h00);
        check("shutdown reset", 32'h0, rd);
        bus(1'b1, 5'h00, 8'hff);
        bus(1'b0, 5'h00, 8'h00);
        check("control0 fields", 32'hf9, rd);
        bus(1'b0, 5'h18, 8'h00);
        check("unmapped read", 32'h0, rd);
    endtask

    // Inverted polarity is chosen so a wrongly inverted override would show.
    task automatic t_config();
        bus(1'b1, 5'h00, 8'h00);
        bus(1'b1, 5'h08, 8'h00);
        bus(1'b1, 5'h0c, 8'h00);
        bus(1'b1, 5'h04, 8'h91);
        bus(1'b1, 5'h00, 8'hf8);
        cyc(6);
        gates("start override", 2'h2);
    endtask

    task automatic t_release_force();
        bus(1'b1, 5'h04, 8'h01);
        cyc(6);
        gates("held before edge", 2'h0);
        drive(1'b1, 2'h0);
        cyc(3);
        drive(1'b0, 2'h0);
        cyc(6);
        gates("running low", 2'h2);
        bus(1'b1, 5'h04, 8'ha1);
        cyc(6);
        gates("forced override", 2'h1);
        check("irq masked", 32'h0, 32'(irq));
        bus(1'b1, 5'h14, 8'h01);
        cyc(2);
        check("irq raised", 32'h1, 32'(irq));
        bus(1'b1, 5'h10, 8'h01);
        cyc(2);
        check("irq cleared", 32'h0, 32'(irq));
        bus(1'b0, 5'h10, 8'h00);
        check("irq status", 32'h2, rd);
    endtask

    task automatic t_fault_hold();
        drive(1'b0, 2'h1);
        bus(1'b1, 5'h04, 8'h21);
        bus(1'b0, 5'h04, 8'h00);
        check("active kept", 32'h1, 32'(rd[SD_ACTIVE]));
        drive(1'b1, 2'h1);
        cyc(3);
        gates("fault override", 2'h1);
        drive(1'b0, 2'h0);
        cyc(3);
        gates("no auto restart", 2'h1);
        bus(1'b1, 5'h04, 8'h21);
        bus(1'b0, 5'h04, 8'h00);
        check("active cleared", 32'h0, 32'(rd[SD_ACTIVE]));
        cyc(6);
        gates("held until edge", 2'h1);
        drive(1'b1, 2'h0);
        cyc(3);
        drive(1'b0, 2'h0);
        cyc(6);
        gates("resumed", 2'h2);
    endtask

    task automatic t_auto();
        drive(1'b0, 2'h2);
        bus(1'b1, 5'h04, 8'hc2);
        bus(1'b0, 5'h04, 8'h00);
        check("auto held by fault", 32'h1, 32'(rd[SD_ACTIVE]));
        cyc(0);
        gates("auto override", 2'h0);
        drive(1'b0, 2'h0);
        cyc(4);
        bus(1'b0, 5'h04, 8'h00);
        check("auto clear", 32'h0, 32'(rd[SD_ACTIVE]));
        cyc(0);
        gates("auto held", 2'h0);
        drive(1'b1, 2'h0);
        cyc(3);
        drive(1'b0, 2'h0);
        cyc(6);
        gates("auto resumed", 2'h2);
    endtask

    // Dead bands in system clocks, then in oscillator ticks, so a wrong clock choice shows.
    task automatic t_deadband();
        bus(1'b1, 5'h08, 8'h04);
        bus(1'b1, 5'h0c, 8'h03);
        bus(1'b1, 5'h00, 8'he0);
        drive(1'b1, 2'h0);
        cyc(5);
        gates("rise dead band", 2'h0);
        cyc(1);
        gates("rise dead band end", 2'h2);
        drive(1'b0, 2'h0);
        cyc(4);
        gates("fall dead band", 2'h0);
        cyc(1);
        gates("fall dead band end", 2'h1);
        bus(1'b1, 5'h00, 8'he1);
        drive(1'b1, 2'h0);
        cyc(8);
        gates("tick dead band", 2'h0);
        cyc(14);
        gates("tick dead band end", 2'h2);
        bus(1'b1, 5'h00, 8'hf8);
        drive(1'b0, 2'h0);
        cyc(6);
    endtask

    task automatic t_enables();
        bus(1'b1, 5'h00, 8'hb8);
        cyc(4);
        check("a only driven", 32'h1, 32'({pins.a_oe_n, pins.b_oe_n}));
        gates("b released", 2'h2);
        bus(1'b1, 5'h00, 8'h78);
        cyc(4);
        check("disabled released", 32'h3, 32'({pins.a_oe_n, pins.b_oe_n}));
        gates("disabled", 2'h0);
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        t_regs();
        t_config();
        t_release_force();
        t_fault_hold();
        t_auto();
        t_deadband();
        t_enables();
        report_and_stop();
    end
endmodule // cws_ctrl_tb_top

bind cws_ctrl cws_ctrl_sva u_sva (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wave_in(wave_in),
    .shutdown_in(shutdown_in), .pins(pins));
